// [aam_pkg.sv]
// Constants and carrier types for the axis alarm monitor
package aam_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] OFF_ALARM  = 5'h00;
  localparam logic [4:0] OFF_WARN   = 5'h04;
  localparam logic [4:0] OFF_DCODE  = 5'h08;
  localparam logic [4:0] OFF_STATUS = 5'h0C;
  localparam logic [4:0] OFF_CTRL   = 5'h10;
  localparam logic [4:0] OFF_CMD    = 5'h14;

  // Axis alarm word bit positions
  localparam int B_DRV_ERR   = 0;
  localparam int B_POS_OT    = 1;
  localparam int B_NEG_OT    = 2;
  localparam int B_POS_SL    = 3;
  localparam int B_NEG_SL    = 4;
  localparam int B_SERVO_OFF = 5;
  localparam int B_POS_TIME  = 6;
  localparam int B_MOVE_AMT  = 7;
  localparam int B_SPEED     = 8;
  localparam int B_FOLLOW    = 9;
  localparam int B_FLT_TYPE  = 10;
  localparam int B_FLT_TC    = 11;
  localparam int B_ZERO_NSET = 13;
  localparam int B_SYNC_ERR  = 16;
  localparam int B_COMM_ERR  = 17;
  localparam int B_CMD_TO    = 18;
  localparam int B_ABS_OVF   = 19;

  // Bits that can ever be set; reserved and unused bits stay zero
  localparam logic [31:0] ALARM_MASK = 32'h000F2FFF;
  // Alarm bits detected by neighbouring logic and only latched here
  localparam logic [31:0] EXT_MASK   = 32'h00002FC0;

  // Servo command status word bits
  localparam int S_BUSY    = 0;
  localparam int S_ZERO_OK = 1;
  localparam int S_FOLLOW  = 2;
  localparam int S_CMD_ERR = 3;

  // Control word bits
  localparam int C_ALM_RST = 0;

  // Motion command word fields
  localparam int CMD_DIR_BIT = 8;
  localparam logic [3:0] CMD_NONE = 4'h0;
  localparam logic [3:0] CMD_POSN = 4'h1;
  localparam logic [3:0] CMD_ZERO_RETURN_COMMAND = 4'h2;
  localparam logic [3:0] CMD_ZERO_SET_COMMAND = 4'h3;
  localparam logic [3:0] CMD_JOG  = 4'h4;

  localparam logic [31:0] ZERO_W = 32'h00000000;

  typedef enum logic [1:0] {AAM_IDLE, AAM_RUN, AAM_DECEL, AAM_WAIT_CLR} aam_state_e;

  // Status reported by the networked servo drive
  typedef struct packed {
    logic        alarm;
    logic [15:0] code;
    logic        sync_err;
    logic        comm_err;
    logic        cmd_timeout;
    logic        abs_ovf;
    logic        servo_on;
  } aam_drive_s;

  // Limit inputs: ok is high while the axis is inside its travel range
  typedef struct packed {
    logic pos_ot_ok;
    logic neg_ot_ok;
    logic pos_sl_hit;
    logic neg_sl_hit;
  } aam_limits_s;

endpackage

// [aam_sticky.sv]
// Sticky flag vector: set wins over clear
`timescale 1ns/100ps
`default_nettype none
module aam_sticky #(
  parameter int W = 32
) (
  input  wire logic         sys_clk, // Clock
  input  wire logic         rst,     // Sync reset, high
  input  wire logic [W-1:0] set,     // Set strobes
  input  wire logic         clr,     // Clear all
  output logic      [W-1:0] q        // Flags
);

  logic [W-1:0] q_d;

  always_comb begin
    q_d = (clr ? '0 : q) | set;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= q_d;
    end
  end

endmodule // aam_sticky
`default_nettype wire

// [aam_axis_alarm_monitor.sv]
// Axis alarm monitor: alarm word, motion abort and Avalon-MM registers
// Operation
// - bits 0-4 drive error, overtravel, soft limits
// - bits 5-9 servo off through following error
// - bits 10, 11 filter errors, 13 zero unset
// - bits 16-18 drive sync, comm, timeout errors
// - bit 19 absolute encoder count overflow
// - bits 20-21 reserved, others unused read zero
// - warning word readable beside alarm word
// - drive alarm watched always, sets drive error
// - every drive alarm code sets same flag
// - drive alarm code readable separately
// - drive error aborts command, decelerates axis
// - drive error or overtravel sets command error
// - overtravel inputs checked while command runs
// - only limit in moving direction counts
// - overtravel cancels, decelerates, then follow-up each scan
// - moves into active overtravel rejected, realarmed
// - soft limit stops axis, valid after zeroing
`timescale 1ns/100ps
`default_nettype none
module aam_axis_alarm_monitor (
  input  wire logic                 sys_clk,           // 200 MHz clock
  input  wire logic                 rst,               // Sync reset, high
  input  wire logic [4:0]           avs_address,       // Byte address
  input  wire logic                 avs_read,          // Read strobe
  input  wire logic                 avs_write,         // Write strobe
  input  wire logic [31:0]          avs_writedata,     // Write data
  input  wire logic [3:0]           avs_byteenable,    // Byte enables
  output logic      [31:0]          avs_readdata,      // Read data
  output logic                      avs_waitrequest,   // Wait request
  input  wire aam_pkg::aam_drive_s  drive,             // Drive status
  input  wire aam_pkg::aam_limits_s limits,            // Limit inputs
  input  wire logic [31:0]          ext_fault,         // Other fault pulses
  input  wire logic [31:0]          warn_in,           // Warning sources
  input  wire logic                 scan_tick,         // Scan cycle pulse
  input  wire logic                 motion_done,       // Command finished
  input  wire logic                 axis_stopped,      // Axis at rest
  input  wire logic [31:0]          fb_pos,            // Feedback position
  input  wire logic [31:0]          ref_pos,           // Reference position
  output logic                      move_active,       // Motion running
  output logic                      move_dir,          // 1 = positive
  output logic                      decel_req,         // Decelerate to stop
  output logic      [31:0]          machine_pos        // Machine position
);

  aam_pkg::aam_state_e state_q, state_d;
  logic [3:0]  code_q, code_d;
  logic        dir_q, dir_d;
  logic        zero_ok_q, zero_ok_d;
  logic        follow_q, follow_d;
  logic        ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] warn_q, warn_d;
  logic [15:0] dcode_q, dcode_d;
  logic [31:0] mpos_q, mpos_d;
  logic [31:0] alarm_q, alarm_set;
  logic [0:0]  cerr_q, cerr_set;
  logic        alm_rst, wr_cmd, req;
  logic        is_move, start, ot_run, sl_run;

  // Bus handshake: one wait cycle, answer on the second
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = rdata_q;
  assign alm_rst = avs_write & ack_q & (avs_address == aam_pkg::OFF_CTRL)
                   & avs_byteenable[0] & avs_writedata[aam_pkg::C_ALM_RST];
  assign wr_cmd  = avs_write & ack_q & (avs_address == aam_pkg::OFF_CMD);

  assign is_move = (code_q == aam_pkg::CMD_POSN) | (code_q == aam_pkg::CMD_ZERO_RETURN_COMMAND)
                   | (code_q == aam_pkg::CMD_JOG);
  assign start   = (state_q == aam_pkg::AAM_IDLE) & (code_q != aam_pkg::CMD_NONE);
  // Only the limit ahead of the axis matters while moving
  assign ot_run  = dir_q ? ~limits.pos_ot_ok : ~limits.neg_ot_ok;
  assign sl_run  = zero_ok_q & (dir_q ? limits.pos_sl_hit : limits.neg_sl_hit);

  // Alarm word and command error latches
  aam_sticky #(.W(32)) u_alarm (
    .sys_clk (sys_clk),
    .rst     (rst),
    .set     (alarm_set & aam_pkg::ALARM_MASK),
    .clr     (alm_rst),
    .q       (alarm_q)
  );

  aam_sticky #(.W(1)) u_cerr (
    .sys_clk (sys_clk),
    .rst     (rst),
    .set     (cerr_set),
    .clr     (alm_rst),
    .q       (cerr_q)
  );

  // Motion command sequencing and alarm detection
  always_comb begin
    state_d   = state_q;
    code_d    = code_q;
    dir_d     = dir_q;
    zero_ok_d = zero_ok_q;
    follow_d  = follow_q;
    alarm_set = aam_pkg::ZERO_W;
    cerr_set  = 1'b0;
    // Drive status is watched in every state, not only during motion
    alarm_set[aam_pkg::B_DRV_ERR]  = drive.alarm;
    alarm_set[aam_pkg::B_SYNC_ERR] = drive.sync_err;
    alarm_set[aam_pkg::B_COMM_ERR] = drive.comm_err;
    alarm_set[aam_pkg::B_CMD_TO]   = drive.cmd_timeout;
    alarm_set[aam_pkg::B_ABS_OVF]  = drive.abs_ovf;
    alarm_set = alarm_set | (ext_fault & aam_pkg::EXT_MASK);
    if (drive.alarm) begin
      cerr_set = 1'b1;
    end
    if (wr_cmd) begin
      code_d = avs_writedata[3:0];
      dir_d  = avs_writedata[aam_pkg::CMD_DIR_BIT];
    end
    unique case (state_q)
      aam_pkg::AAM_IDLE: begin
        if (start) begin
          follow_d = 1'b0;
          if (code_q == aam_pkg::CMD_ZERO_SET_COMMAND) begin
            zero_ok_d = 1'b1;
            state_d   = aam_pkg::AAM_WAIT_CLR;
          end else if (!is_move) begin
            state_d = aam_pkg::AAM_WAIT_CLR;
          end else if (!drive.servo_on) begin
            alarm_set[aam_pkg::B_SERVO_OFF] = 1'b1;
            cerr_set = 1'b1;
            state_d  = aam_pkg::AAM_WAIT_CLR;
          end else if (ot_run) begin
            // Move into an active overtravel is refused and flagged again
            alarm_set[aam_pkg::B_POS_OT] = dir_q;
            alarm_set[aam_pkg::B_NEG_OT] = ~dir_q;
            cerr_set = 1'b1;
            state_d  = aam_pkg::AAM_WAIT_CLR;
          end else if (drive.alarm) begin
            state_d = aam_pkg::AAM_WAIT_CLR;
          end else begin
            state_d = aam_pkg::AAM_RUN;
          end
        end
      end
      aam_pkg::AAM_RUN: begin
        if (ot_run) begin
          alarm_set[aam_pkg::B_POS_OT] = dir_q;
          alarm_set[aam_pkg::B_NEG_OT] = ~dir_q;
          cerr_set = 1'b1;
          follow_d = 1'b1;
          state_d  = aam_pkg::AAM_DECEL;
        end else if (drive.alarm) begin
          state_d = aam_pkg::AAM_DECEL;
        end else if (sl_run) begin
          alarm_set[aam_pkg::B_POS_SL] = dir_q;
          alarm_set[aam_pkg::B_NEG_SL] = ~dir_q;
          cerr_set = 1'b1;
          state_d  = aam_pkg::AAM_DECEL;
        end else if (motion_done) begin
          if (code_q == aam_pkg::CMD_ZERO_RETURN_COMMAND) begin
            zero_ok_d = 1'b1;
          end
          state_d = aam_pkg::AAM_WAIT_CLR;
        end
      end
      aam_pkg::AAM_DECEL: begin
        if (axis_stopped) begin
          state_d = aam_pkg::AAM_WAIT_CLR;
        end
      end
      aam_pkg::AAM_WAIT_CLR: begin
        // A new command needs the command code cleared first
        if (code_q == aam_pkg::CMD_NONE) begin
          state_d = aam_pkg::AAM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q   <= aam_pkg::AAM_IDLE;
      code_q    <= aam_pkg::CMD_NONE;
      dir_q     <= 1'b0;
      zero_ok_q <= 1'b0;
      follow_q  <= 1'b0;
    end else begin
      state_q   <= state_d;
      code_q    <= code_d;
      dir_q     <= dir_d;
      zero_ok_q <= zero_ok_d;
      follow_q  <= follow_d;
    end
  end

  assign move_active = (state_q == aam_pkg::AAM_RUN);
  assign move_dir    = dir_q;
  assign decel_req   = (state_q == aam_pkg::AAM_DECEL);
  assign machine_pos = mpos_q;

  // Monitored words and position follow-up
  always_comb begin
    warn_d  = warn_in;
    dcode_d = drive.alarm ? drive.code : dcode_q;
    mpos_d  = mpos_q;
    if (scan_tick) begin
      // Once stopped after overtravel, machine position follows reference
      if (follow_q && state_q == aam_pkg::AAM_WAIT_CLR) begin
        mpos_d = ref_pos;
      end else begin
        mpos_d = fb_pos;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      warn_q  <= aam_pkg::ZERO_W;
      dcode_q <= 16'h0000;
      mpos_q  <= aam_pkg::ZERO_W;
    end else begin
      warn_q  <= warn_d;
      dcode_q <= dcode_d;
      mpos_q  <= mpos_d;
    end
  end

  // Register read path; data are ready when waitrequest drops
  always_comb begin
    ack_d   = req & ~ack_q;
    rdata_d = rdata_q;
    if (avs_read && !ack_q) begin
      unique case (avs_address)
        aam_pkg::OFF_ALARM:  rdata_d = alarm_q;
        aam_pkg::OFF_WARN:   rdata_d = warn_q;
        aam_pkg::OFF_DCODE:  rdata_d = {16'h0000, dcode_q};
        aam_pkg::OFF_STATUS: begin
          rdata_d = aam_pkg::ZERO_W;
          rdata_d[aam_pkg::S_BUSY]    = (state_q != aam_pkg::AAM_IDLE);
          rdata_d[aam_pkg::S_ZERO_OK] = zero_ok_q;
          rdata_d[aam_pkg::S_FOLLOW]  = follow_q;
          rdata_d[aam_pkg::S_CMD_ERR] = cerr_q[0];
        end
        aam_pkg::OFF_CMD:    rdata_d = {23'h000000, dir_q, 4'h0, code_q};
        default:             rdata_d = aam_pkg::ZERO_W;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_q   <= 1'b0;
      rdata_q <= aam_pkg::ZERO_W;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

endmodule // aam_axis_alarm_monitor
`default_nettype wire

// [aam_drive_model.sv]
// Networked servo drive and axis motion model for the alarm monitor bench
`timescale 1ns/100ps
`default_nettype none
module aam_drive_model (
  input  wire logic          sys_clk,      // Clock
  input  wire logic          rst,          // Sync reset, high
  input  wire logic          decel_req,    // Stop request
  input  wire logic          move_active,  // Motion running
  input  wire logic          slow,         // Long ramp down
  input  wire logic [20:0]   drv_set,      // Alarm, code, link errors
  input  wire logic          servo_on,     // Servo on
  output var aam_pkg::aam_drive_s drive,   // Drive status
  output var logic           axis_stopped, // Axis at rest
  output var logic  [31:0]   fb_pos        // Feedback position
);
  logic [2:0] cnt_q;
  always_ff @(posedge sys_clk) begin
    if (rst || !decel_req) cnt_q <= 3'h0;
    else if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
  end
  always_ff @(posedge sys_clk) fb_pos <= rst ? 32'h0 : fb_pos + {31'h0, move_active};
  // Drive ramps itself down, then zero clamp holds it at rest
  assign axis_stopped = !move_active && (!decel_req || !slow || cnt_q == 3'h7);
  assign drive = {drv_set, servo_on};
endmodule // aam_drive_model
`default_nettype wire

// [aam_checker.sv]
// Port assertions for the axis alarm monitor
`timescale 1ns/100ps
`default_nettype none
module aam_checker (
  input wire logic                 sys_clk,         // Clock
  input wire logic                 rst,             // Reset
  input wire logic                 avs_read,        // Read
  input wire logic                 avs_write,       // Write
  input wire logic                 avs_waitrequest, // Wait
  input wire aam_pkg::aam_drive_s  drive,           // Drive
  input wire aam_pkg::aam_limits_s limits,          // Limits
  input wire logic                 scan_tick,       // Scan
  input wire logic                 motion_done,     // Done
  input wire logic                 axis_stopped,    // At rest
  input wire logic [31:0]          ref_pos,         // Reference
  input wire logic                 move_active,     // Running
  input wire logic                 move_dir,        // Direction
  input wire logic                 decel_req,       // Stopping
  input wire logic [31:0]          machine_pos      // Machine pos
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Soft limits may end a run, so they are excluded where a run must go on
  wire run_ok = !motion_done && !limits.pos_sl_hit && !limits.neg_sl_hit;
  sequence s_ot_hit;
    move_active && move_dir && !limits.pos_ot_ok && !motion_done;
  endsequence
  sequence s_ot_stop;
    s_ot_hit ##1 decel_req && axis_stopped ##1 scan_tick;
  endsequence
  property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("wait held too long");
  property p_idle; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("wait while idle");
  property p_drv; move_active && drive.alarm && !motion_done |=> decel_req && !move_active; endproperty
  a_drv: assert property (p_drv) else $error("drive alarm no abort");
  property p_otp; s_ot_hit |=> decel_req; endproperty
  a_otp: assert property (p_otp) else $error("pos overtravel no stop");
  property p_otn; move_active && !move_dir && !limits.neg_ot_ok && !motion_done |=> decel_req; endproperty
  a_otn: assert property (p_otn) else $error("neg overtravel no stop");
  property p_ign;
    move_active && move_dir && limits.pos_ot_ok && !drive.alarm && run_ok |=> move_active;
  endproperty
  a_ign: assert property (p_ign) else $error("run ended wrongly");
  property p_hold; decel_req && !axis_stopped |=> decel_req; endproperty
  a_hold: assert property (p_hold) else $error("decel dropped early");
  property p_end; decel_req && axis_stopped |=> !decel_req && !move_active; endproperty
  a_end: assert property (p_end) else $error("decel not ended");
  property p_fol; s_ot_stop |=> machine_pos == $past(ref_pos); endproperty
  a_fol: assert property (p_fol) else $error("no follow-up");
endmodule // aam_checker
bind aam_axis_alarm_monitor aam_checker aam_checker_inst (.sys_clk, .rst, .avs_read,
  .avs_write, .avs_waitrequest, .drive, .limits, .scan_tick, .motion_done, .axis_stopped,
  .ref_pos, .move_active, .move_dir, .decel_req, .machine_pos);
`default_nettype wire

// [aam_axis_alarm_monitor_tb_top.sv]
// Self-checking bench for the axis alarm monitor
`timescale 1ns/100ps
`default_nettype none
module aam_axis_alarm_monitor_tb_top;
  logic sys_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, slow = 1'b0;
  logic scan_tick = 1'b0, motion_done = 1'b0, son = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, ext_fault = 32'h0, warn_in = 32'h0, ref_pos = 32'h0;
  logic [31:0] rdat, avs_readdata, machine_pos, fb_pos;
  logic [20:0] drv_set = 21'h0;
  aam_pkg::aam_limits_s limits = 4'hC;
  aam_pkg::aam_drive_s  drive;
  logic avs_waitrequest, move_active, move_dir, decel_req, axis_stopped;
  int err_total = 0;
  int n_compared = 0;
  always #2.5 sys_clk = ~sys_clk;
  aam_axis_alarm_monitor aam_axis_alarm_monitor_inst (.sys_clk, .rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
    .avs_waitrequest, .drive, .limits, .ext_fault, .warn_in, .scan_tick, .motion_done,
    .axis_stopped, .fb_pos, .ref_pos, .move_active, .move_dir, .decel_req, .machine_pos);
  aam_drive_model aam_drive_model_inst (.sys_clk, .rst, .decel_req, .move_active, .slow,
    .drv_set, .servo_on(son), .drive, .axis_stopped, .fb_pos);
  task automatic tally_and_finish;
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // Waitrequest and read data are judged at the rising edge that ends the access
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) err_total++;
    if (n == 20) tally_and_finish();
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic cmd(input logic [31:0] d);
    bus(1'b1, aam_pkg::OFF_CMD, d);
  endtask
  task automatic arst;
    bus(1'b1, aam_pkg::OFF_CTRL, 32'h1);
  endtask
  task automatic rda(input logic [31:0] e);
    bus(1'b0, aam_pkg::OFF_ALARM, 32'h0);
    chk("alarm", e, rdat);
  endtask
  task automatic wt(ref logic s, input logic v);
    int n;
    for (n = 0; n < 50; n++) begin
      @(negedge sys_clk);
      if (s === v) break;
    end
    if (n == 50) err_total++;
    if (n == 50) tally_and_finish();
    @(posedge sys_clk);
  endtask
  task automatic pulse_done;
    motion_done <= 1'b1;
    @(posedge sys_clk);
    motion_done <= 1'b0;
  endtask
  task automatic t_regs;
    warn_in <= 32'hA5A50F0F;
    bus(1'b1, aam_pkg::OFF_ALARM, 32'hFFFFFFFF);
    rda(32'h0);
    bus(1'b0, aam_pkg::OFF_WARN, 32'h0);
    chk("warn", 32'hA5A50F0F, rdat);
    bus(1'b0, 5'h18, 32'h0);
    chk("unmapped", 32'h0, rdat);
  endtask
  task automatic t_drv;
    logic [15:0] c[2] = '{16'h0A51, 16'h0C90};
    for (int i = 0; i < 2; i++) begin
      drv_set <= {1'b1, c[i], 4'h0};
      repeat (2) @(posedge sys_clk);
      drv_set <= 21'h0;
      rda(32'h1);
      bus(1'b0, aam_pkg::OFF_DCODE, 32'h0);
      chk("code", {16'h0, c[i]}, {16'h0, rdat[15:0]});
      bus(1'b0, aam_pkg::OFF_STATUS, 32'h0);
      chk("cmd_err", 32'h8, rdat);
      arst();
      rda(32'h0);
    end
  endtask
  task automatic t_abort;
    slow <= 1'b1;
    cmd(32'h101);
    wt(move_active, 1'b1);
    bus(1'b0, aam_pkg::OFF_CMD, 32'h0);
    chk("cmd", 32'h101, rdat);
    drv_set <= 21'h100000;
    wt(decel_req, 1'b1);
    chk("hold", 32'h0, {31'h0, axis_stopped});
    wt(decel_req, 1'b0);
    chk("active", 32'h0, {31'h0, move_active});
    drv_set <= 21'h0;
    slow <= 1'b0;
    cmd(32'h0);
    arst();
  endtask
  task automatic t_ot;
    cmd(32'h101);
    wt(move_active, 1'b1);
    limits.neg_ot_ok <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("run", 32'h1, {31'h0, move_active});
    ref_pos <= 32'h00012340;
    scan_tick <= 1'b1;
    limits.pos_ot_ok <= 1'b0;
    wt(decel_req, 1'b1);
    wt(decel_req, 1'b0);
    // Follow-up lands one edge after the stop; look once it has settled
    @(negedge sys_clk);
    chk("mpos", 32'h00012340, machine_pos);
    @(posedge sys_clk);
    scan_tick <= 1'b0;
    rda(32'h2);
    bus(1'b0, aam_pkg::OFF_STATUS, 32'h0);
    chk("status", 32'hD, rdat);
    cmd(32'h0);
    arst();
    cmd(32'h101);
    repeat (3) @(posedge sys_clk);
    chk("reject", 32'h0, {31'h0, move_active});
    rda(32'h2);
    limits <= 4'h4;
    cmd(32'h0);
    arst();
    cmd(32'h004);
    wt(move_active, 1'b1);
    limits <= 4'hC;
    pulse_done();
    cmd(32'h0);
  endtask
  task automatic t_lim;
    son <= 1'b0;
    cmd(32'h101);
    repeat (3) @(posedge sys_clk);
    rda(32'h20);
    son <= 1'b1;
    cmd(32'h0);
    arst();
    limits.pos_sl_hit <= 1'b1;
    cmd(32'h101);
    wt(move_active, 1'b1);
    repeat (3) @(posedge sys_clk);
    chk("unzeroed", 32'h1, {31'h0, move_active});
    pulse_done();
    cmd(32'h0);
    cmd(32'h2);
    wt(move_active, 1'b1);
    pulse_done();
    bus(1'b0, aam_pkg::OFF_STATUS, 32'h0);
    chk("status", 32'h3, rdat);
    cmd(32'h0);
    cmd(32'h3);
    pulse_done();
    cmd(32'h0);
    cmd(32'h101);
    wt(decel_req, 1'b1);
    wt(decel_req, 1'b0);
    rda(32'h8);
    limits <= 4'hC;
    cmd(32'h0);
    arst();
  endtask
  task automatic t_errs;
    drv_set <= 21'hF;
    ext_fault <= 32'hFFFFFFFF;
    repeat (2) @(posedge sys_clk);
    drv_set <= 21'h0;
    ext_fault <= 32'h0;
    rda(32'h000F2FC0);
    arst();
    rda(32'h0);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_drv();
    t_abort();
    t_ot();
    t_lim();
    t_errs();
    tally_and_finish();
  end
endmodule // aam_axis_alarm_monitor_tb_top
`default_nettype wire
